// file: bg_record_parser.sv
// Fetches and parses the background parameter record from texture memory.
// Assumes a word read port on the same clock: req held until valid.
`timescale 1ns/1ps

module bg_record_parser
  import draw_order_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [31:0] base_addr,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [31:0] mem_rdata,
  output logic done,
  output bg_rec_t rec
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [31:0] base;
    logic [4:0] word;
    logic [1:0] vtx;
    logic [2:0] fld;
    bg_rec_t rec;
  } prs_state_t;

  prs_state_t s_q, s_d;
  logic [2:0] nf;

  assign mem_req = s_q.busy;
  assign mem_addr = s_q.base + {25'h0000000, s_q.word, 2'b00};
  assign done = s_q.done;
  assign rec = s_q.rec;

  // Record walk: header words, then three vertices with optional fields
  always_comb begin
    s_d = s_q;
    nf = 3'h0;
    s_d.done = 1'b0;
    if (start) begin
      s_d.busy = 1'b1;
      s_d.base = base_addr;
      s_d.word = 5'h00;
      s_d.vtx = 2'h0;
      s_d.fld = 3'h0;
    end else if (s_q.busy && mem_valid) begin
      s_d.word = s_q.word + 5'h01;
      if (s_q.word < 5'(`HDR_WORDS)) begin
        // Control word content is don't-care but still occupies a slot
        if (s_q.word == 5'h00) s_d.rec.hidden_surface_engine = mem_rdata;
        if (s_q.word == 5'h01) s_d.rec.texture_shading_engine = mem_rdata;
      end else begin
        // Vertex depth is skipped; the depth register governs background
        unique case (s_q.fld)
          3'h0: s_d.rec.vx[s_q.vtx] = mem_rdata;
          3'h1: s_d.rec.vy[s_q.vtx] = mem_rdata;
          3'h5: s_d.rec.base[s_q.vtx] = mem_rdata;
          default: ;
        endcase
        nf = s_q.fld + 3'h1;
        if (nf == 3'h3 && !s_q.rec.hidden_surface_engine[`ISP_TEX_BIT]) nf = 3'h5;
        if (nf == 3'h6 && !s_q.rec.hidden_surface_engine[`ISP_OFS_BIT]) nf = 3'h7;
        s_d.fld = nf;
        if (nf == 3'h7) begin
          s_d.fld = 3'h0;
          s_d.vtx = s_q.vtx + 2'h1;
          if (s_q.vtx == 2'h2) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
          end
        end
      end
    end
    // Fourth corner derived from the other three once parsing ends
    if (s_q.done) begin
      s_d.rec.vx[3] = s_q.rec.vx[1] + s_q.rec.vx[2] - s_q.rec.vx[0];
      s_d.rec.vy[3] = s_q.rec.vy[1] + s_q.rec.vy[2] - s_q.rec.vy[0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// file: depth_test.sv
// Depth compare unit: one fragment depth against the buffered depth.
// Assumes purely combinational use inside the draw-order block.
`timescale 1ns/1ps

module depth_test
  import draw_order_pkg::*;
(
  input wire dcmp_t mode,
  input wire logic [31:0] z_new,
  input wire logic [31:0] z_buf,
  output logic pass
);

  // Larger depth value is nearer the viewer
  always_comb begin
    unique case (mode)
      DC_NEVER: pass = 1'b0;
      DC_LESS: pass = z_new < z_buf;
      DC_EQUAL: pass = z_new == z_buf;
      DC_LEQUAL: pass = z_new <= z_buf;
      DC_GREATER: pass = z_new > z_buf;
      DC_NOTEQUAL: pass = z_new != z_buf;
      DC_GEQUAL: pass = z_new >= z_buf;
      DC_ALWAYS: pass = 1'b1;
    endcase
  end

endmodule

// file: draw_order_asserts.sv
// Checker on the ports of the draw-order block.
// Assumes it is bound to every instance of that block.
`timescale 1ns/1ps
module draw_order_asserts
  import draw_order_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_valid,
  input wire logic tile_start,
  input wire logic tile_busy,
  input wire logic tile_done,
  input wire logic frag_ready,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire pix_t pix,
  input wire bg_rec_t bg_params
);
  // ----------------------------------------
  // Properties on one clock
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_bus; hreadyout && !hresp; endproperty
  property p_fetch; tile_start && !tile_busy |-> ##2 mem_req; endproperty
  property p_hold; mem_req && !mem_valid |=> mem_req && $stable(mem_addr); endproperty
  property p_step;
    mem_req && mem_valid |=> !mem_req || mem_addr == $past(mem_addr) + 32'h4;
  endproperty
  property p_vx4;
    tile_done |-> bg_params.vx[3] == bg_params.vx[1] + bg_params.vx[2] - bg_params.vx[0]
      && bg_params.vy[3] == bg_params.vy[1] + bg_params.vy[2] - bg_params.vy[0];
  endproperty
  property p_cut;
    pix_valid && pix.kind == PK_CUTOUT |-> pix.alpha == 8'hff && !pix.blend;
  endproperty
  property p_stall; pix_valid && !pix_ready |=> pix_valid && $stable(pix); endproperty
  property p_draw; frag_ready |-> tile_busy && !mem_req; endproperty
  property p_busy; tile_start && !tile_busy |=> tile_busy; endproperty
  a_bus: assert property (p_bus) else $error("bus wait or error");
  a_fetch: assert property (p_fetch) else $error("no record fetch");
  a_hold: assert property (p_hold) else $error("read dropped");
  a_step: assert property (p_step) else $error("bad word step");
  a_vx4: assert property (p_vx4) else $error("bad fourth vertex");
  a_cut: assert property (p_cut) else $error("cutout not opaque");
  a_stall: assert property (p_stall) else $error("pixel moved in stall");
  a_draw: assert property (p_draw) else $error("load outside its phase");
  a_busy: assert property (p_busy) else $error("busy missing");
  // Main scenarios reached
  c_done: cover property (tile_done);
  c_trans: cover property (pix_valid && pix_ready && pix.kind == PK_TRANS);
  c_slow: cover property (mem_req && !mem_valid ##1 mem_valid);
endmodule

bind pixel_sort_draw_order_control draw_order_asserts u_chk (.*);

// file: draw_order_defs.svh
// Offsets, field positions, reset values and sizes for the draw-order block.
// Assumes inclusion by draw_order_pkg and by every design file that needs it.
`ifndef DRAW_ORDER_DEFS_SVH
`define DRAW_ORDER_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define NPIX 32
`define PIX_W 5
`define CACHE_DEPTH 128
`define CNT_W 8
`define HDR_WORDS 3

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_BG_PTR 8'h00
`define OFS_BG_DEPTH 8'h04
`define OFS_FEED_CFG 8'h08
`define OFS_PARAM_CFG 8'h0c
`define OFS_ALPHA_THR 8'h10
`define OFS_STATUS 8'h14

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define FEED_PRESORT_BIT 0
`define FEED_TCACHE_LSB 4
`define FEED_TCACHE_MSB 13
`define FEED_CHUNK_LSB 14
`define FEED_CHUNK_MSB 23
`define PRC_REGION_BIT 21
`define ISP_TEX_BIT 25
`define ISP_OFS_BIT 24

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define RST_BG_PTR 32'h0000_0000
`define RST_BG_DEPTH 32'h0000_0000
`define RST_FEED_CFG 32'h0010_0800
`define RST_PARAM_CFG 32'h0000_0000
`define RST_ALPHA_THR 8'hff
`define ALPHA_OPAQUE 8'hff

`endif

// file: draw_order_pkg.sv
// Types shared by the draw-order block and its helpers.
// Assumes draw_order_defs.svh sits in the include path.
`include "draw_order_defs.svh"

package draw_order_pkg;

  // --------------------------------------------------------------------------
  // Enumerations
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_BG_FETCH = 6'h02,
    PH_LOAD = 6'h04,
    PH_SELECT = 6'h08,
    PH_EMIT = 6'h10,
    PH_BG_FILL = 6'h20
  } phase_t;

  typedef enum logic [2:0] {
    DC_NEVER = 3'h0,
    DC_LESS = 3'h1,
    DC_EQUAL = 3'h2,
    DC_LEQUAL = 3'h3,
    DC_GREATER = 3'h4,
    DC_NOTEQUAL = 3'h5,
    DC_GEQUAL = 3'h6,
    DC_ALWAYS = 3'h7
  } dcmp_t;

  typedef enum logic [1:0] {
    PK_BG = 2'h0,
    PK_CUTOUT = 2'h1,
    PK_TRANS = 2'h2
  } pix_kind_t;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic empty;
    logic last;
    logic [`PIX_W-1:0] pix;
    logic [31:0] z;
    logic [7:0] alpha;
    dcmp_t mode;
  } frag_t;

  typedef struct packed {
    pix_kind_t kind;
    logic [`PIX_W-1:0] pix;
    logic [31:0] z;
    logic [7:0] alpha;
    logic blend;
    logic [`CNT_W-1:0] tag;
  } pix_t;

  typedef struct packed {
    logic [31:0] hidden_surface_engine;
    logic [31:0] texture_shading_engine;
    logic [3:0][31:0] vx;
    logic [3:0][31:0] vy;
    logic [2:0][31:0] base;
  } bg_rec_t;

endpackage

// file: pixel_sort_draw_order_control.sv
// Draw-order control for one tile: background, cutout and translucent passes.
// Assumes an AHB-Lite master, a texture word read port and a fragment source
// on ref_clk, and a shading engine that takes pixels with valid/ready.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

module pixel_sort_draw_order_control
  import draw_order_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [31:0] mem_rdata,
  input wire logic tile_start,
  input wire logic tile_presort,
  output logic tile_busy,
  output logic tile_done,
  output logic trans_modvol_enable,
  input wire logic frag_valid,
  output logic frag_ready,
  input wire frag_t frag,
  output logic pix_valid,
  input wire logic pix_ready,
  output pix_t pix,
  output bg_rec_t bg_params
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] bg_ptr;
    logic [31:0] bg_depth;
    logic [31:0] feed_cfg;
    logic [31:0] param_cfg;
    logic [7:0] alpha_thr;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    phase_t phase;
    logic bg_go;
    logic presort;
    logic trans;
    logic list_end;
    logic found;
    logic tile_done;
    logic [`CNT_W-1:0] cnt;
    logic [`CNT_W-1:0] scan;
    logic [15:0] emitted;
    logic [`CACHE_DEPTH-1:0][$bits(frag_t)-1:0] cache;
    logic [`CACHE_DEPTH-1:0] used;
    logic [`NPIX-1:0] cut_done;
    logic [`NPIX-1:0] covered;
    logic [`NPIX-1:0] best_ok;
    logic [`NPIX-1:0][`CNT_W-1:0] best_idx;
    logic [`NPIX-1:0][31:0] best_z;
    logic [`NPIX-1:0][31:0] zbuf;
    logic out_valid;
    pix_t out;
  } core_state_t;

  core_state_t s_q, s_d;

  logic bg_done;
  bg_rec_t bg_rec;
  frag_t ent;
  logic [`PIX_W-1:0] ep;
  dcmp_t dmode;
  logic zpass;
  logic stall;
  logic [`CNT_W-1:0] limit;
  logic [9:0] lim_raw;
  logic take;
  logic last_scan;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  bg_record_parser u_parser (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(s_q.bg_go),
    .base_addr(s_q.bg_ptr),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_valid(mem_valid),
    .mem_rdata(mem_rdata),
    .done(bg_done),
    .rec(bg_rec)
  );

  // Cache entry under the scan pointer and its depth test
  assign ent = frag_t'(s_q.cache[s_q.scan[`CNT_W-2:0]]);
  assign ep = ent.pix;
  // Sorted passes force greater-or-equal; only the pre-sort translucent pass honours the mode
  assign dmode = (s_q.trans && s_q.presort) ? ent.mode : DC_GEQUAL;

  depth_test u_depth (
    .mode(dmode),
    .z_new(ent.z),
    .z_buf(s_q.zbuf[ep]),
    .pass(zpass)
  );

  // --------------------------------------------------------------------------
  // Ports
  // --------------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign tile_busy = s_q.phase != PH_IDLE;
  assign tile_done = s_q.tile_done;
  assign trans_modvol_enable = !s_q.presort;
  assign frag_ready = (s_q.phase == PH_LOAD) && (s_q.cnt < limit) && !s_q.list_end;
  assign pix_valid = s_q.out_valid;
  assign pix = s_q.out;
  assign bg_params = bg_rec;
  assign stall = s_q.out_valid && !pix_ready;

  // Chunk limit: cutout chunk or translucent cache, clamped to the array
  always_comb begin
    lim_raw = s_q.trans ? s_q.feed_cfg[`FEED_TCACHE_MSB:`FEED_TCACHE_LSB]
                        : s_q.feed_cfg[`FEED_CHUNK_MSB:`FEED_CHUNK_LSB];
    if (lim_raw == 10'h000) begin
      limit = 8'h01;
    end else if (lim_raw > 10'(`CACHE_DEPTH)) begin
      limit = `CNT_W'(`CACHE_DEPTH);
    end else begin
      limit = lim_raw[`CNT_W-1:0];
    end
  end

  // Register read mux; unmapped offsets read as zero
  always_comb begin
    hrdata = 32'h0000_0000;
    unique case (s_q.ap_addr)
      `OFS_BG_PTR: hrdata = s_q.bg_ptr;
      `OFS_BG_DEPTH: hrdata = s_q.bg_depth;
      `OFS_FEED_CFG: hrdata = s_q.feed_cfg;
      `OFS_PARAM_CFG: hrdata = s_q.param_cfg;
      `OFS_ALPHA_THR: hrdata = {24'h000000, s_q.alpha_thr};
      `OFS_STATUS: hrdata = {s_q.emitted, 6'h00, s_q.trans, s_q.presort, 2'h0, s_q.phase};
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    take = 1'b0;
    last_scan = 1'b0;
    s_d.bg_go = 1'b0;
    s_d.tile_done = 1'b0;
    if (s_q.out_valid && pix_ready) s_d.out_valid = 1'b0;

    // Bus address phase capture and data phase write
    s_d.ap_valid = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready) begin
      s_d.ap_addr = haddr[7:0];
      s_d.ap_write = hwrite;
    end
    if (s_q.ap_valid && s_q.ap_write) begin
      unique case (s_q.ap_addr)
        `OFS_BG_PTR: s_d.bg_ptr = hwdata;
        `OFS_BG_DEPTH: s_d.bg_depth = hwdata;
        `OFS_FEED_CFG: s_d.feed_cfg = hwdata;
        `OFS_PARAM_CFG: s_d.param_cfg = hwdata;
        `OFS_ALPHA_THR: s_d.alpha_thr = hwdata[7:0];
        default: ;
      endcase
    end

    unique case (s_q.phase)
      // Tile start: choose sort mode, seed depths with background depth
      PH_IDLE: begin
        if (tile_start) begin
          s_d.presort = s_q.param_cfg[`PRC_REGION_BIT] ? tile_presort
                                                        : s_q.feed_cfg[`FEED_PRESORT_BIT];
          s_d.cut_done = '0;
          s_d.covered = '0;
          s_d.best_ok = '0;
          s_d.used = '0;
          s_d.cnt = '0;
          s_d.scan = '0;
          s_d.trans = 1'b0;
          s_d.list_end = 1'b0;
          s_d.found = 1'b0;
          s_d.emitted = 16'h0000;
          for (int i = 0; i < `NPIX; i++) begin
            s_d.zbuf[i] = s_q.bg_depth;
          end
          s_d.bg_go = 1'b1;
          s_d.phase = PH_BG_FETCH;
        end
      end

      PH_BG_FETCH: begin
        if (bg_done) s_d.phase = PH_LOAD;
      end

      // Fill the cache up to the chunk size or the list end
      PH_LOAD: begin
        if (frag_valid && frag_ready) begin
          if (!frag.empty) begin
            s_d.cache[s_q.cnt[`CNT_W-2:0]] = frag;
            s_d.used[s_q.cnt[`CNT_W-2:0]] = 1'b0;
            s_d.covered[frag.pix] = 1'b1;
            s_d.cnt = s_q.cnt + 8'h01;
          end
          if (frag.last) s_d.list_end = 1'b1;
          if (frag.last || (s_d.cnt >= limit)) begin
            s_d.scan = '0;
            s_d.found = 1'b0;
            s_d.best_ok = '0;
            s_d.phase = (s_q.trans && s_q.presort) ? PH_EMIT : PH_SELECT;
          end
        end
      end

      // One entry per cycle: keep the per-pixel best candidate
      PH_SELECT: begin
        if (s_q.cnt == 8'h00) begin
          s_d.phase = PH_EMIT;
        end else begin
          if (!s_q.used[s_q.scan[`CNT_W-2:0]] && !s_q.cut_done[ep] && zpass) begin
            if (!s_q.best_ok[ep]) begin
              take = 1'b1;
            end else if (s_q.trans) begin
              // Strict compare keeps the earlier entry on a tie
              take = ent.z < s_q.best_z[ep];
            end else begin
              // Later entry wins a tie, so the earlier one ends behind
              take = ent.z >= s_q.best_z[ep];
            end
          end
          if (take) begin
            s_d.best_ok[ep] = 1'b1;
            s_d.best_z[ep] = ent.z;
            s_d.best_idx[ep] = s_q.scan;
            s_d.found = 1'b1;
          end
          s_d.scan = s_q.scan + 8'h01;
          if (s_q.scan == s_q.cnt - 8'h01) begin
            s_d.scan = '0;
            s_d.phase = PH_EMIT;
          end
        end
      end

      // Draw the winners; pre-sort draws in order each entry that passes its depth test on a pixel with no cutout
      PH_EMIT: begin
        if (!stall) begin
          if (s_q.cnt != 8'h00) begin
            if (s_q.trans && s_q.presort) begin
              if (!s_q.cut_done[ep] && zpass) begin
                s_d.zbuf[ep] = ent.z;
                s_d.out = '{PK_TRANS, ep, ent.z, ent.alpha, 1'b1, s_q.scan};
                s_d.out_valid = 1'b1;
              end
            end else if (!s_q.used[s_q.scan[`CNT_W-2:0]] && s_q.best_ok[ep] &&
                         s_q.best_idx[ep] == s_q.scan) begin
              s_d.used[s_q.scan[`CNT_W-2:0]] = 1'b1;
              if (s_q.trans) begin
                s_d.out = '{PK_TRANS, ep, ent.z, ent.alpha, 1'b1, s_q.scan};
                s_d.out_valid = 1'b1;
              end else if (ent.alpha >= s_q.alpha_thr) begin
                s_d.cut_done[ep] = 1'b1;
                s_d.zbuf[ep] = ent.z;
                s_d.out = '{PK_CUTOUT, ep, ent.z, `ALPHA_OPAQUE, 1'b0, s_q.scan};
                s_d.out_valid = 1'b1;
              end
            end
            s_d.scan = s_q.scan + 8'h01;
            last_scan = s_q.scan == s_q.cnt - 8'h01;
          end else begin
            last_scan = 1'b1;
          end
          if (s_d.out_valid) s_d.emitted = s_q.emitted + 16'h0001; // Taken beat already cleared
          if (last_scan) begin
            s_d.scan = '0;
            s_d.best_ok = '0;
            if (s_q.found && !(s_q.trans && s_q.presort)) begin
              // Another layer may remain in this chunk
              s_d.found = 1'b0;
              s_d.phase = PH_SELECT;
            end else begin
              s_d.cnt = '0;
              s_d.used = '0;
              if (!s_q.list_end) begin
                s_d.phase = PH_LOAD;
              end else if (!s_q.trans) begin
                s_d.trans = 1'b1;
                s_d.list_end = 1'b0;
                s_d.phase = PH_LOAD;
              end else begin
                s_d.phase = PH_BG_FILL;
              end
            end
          end
        end
      end

      // Uncovered pixels take the background surface at its register depth
      PH_BG_FILL: begin
        if (!stall) begin
          if (!s_q.covered[s_q.scan[`PIX_W-1:0]]) begin
            s_d.out = '{PK_BG, s_q.scan[`PIX_W-1:0], s_q.bg_depth, `ALPHA_OPAQUE,
                        1'b0, 8'h00};
            s_d.out_valid = 1'b1;
            s_d.emitted = s_q.emitted + 16'h0001;
          end
          s_d.scan = s_q.scan + 8'h01;
          if (s_q.scan == `CNT_W'(`NPIX - 1)) begin
            s_d.scan = '0;
            s_d.tile_done = 1'b1;
            s_d.phase = PH_IDLE;
          end
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.bg_ptr <= `RST_BG_PTR;
      s_q.bg_depth <= `RST_BG_DEPTH;
      s_q.feed_cfg <= `RST_FEED_CFG;
      s_q.param_cfg <= `RST_PARAM_CFG;
      s_q.alpha_thr <= `RST_ALPHA_THR;
      s_q.phase <= PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// file: tb.sv
// Self-checking bench for the draw-order block.
// Assumes the memory model and the bound checker.
`timescale 1ns/1ps
module tb
  import draw_order_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic tile_start = 1'b0;
  logic tile_presort = 1'b0;
  logic frag_valid = 1'b0;
  logic pix_ready = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  frag_t frag = '0;
  dcmp_t fmode = DC_LESS;
  logic hreadyout, hresp, mem_req, mem_valid, tile_busy, tile_done;
  logic trans_modvol_enable, frag_ready, pix_valid;
  logic [31:0] hrdata, mem_addr, mem_rdata, rd;
  pix_t pix;
  bg_rec_t bg_params;
  pix_t q[$];
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  pixel_sort_draw_order_control u_dut (.hready(hreadyout), .*);
  tex_mem_model u_mem (.*);

  // ----------------------------------------
  // Clock, pixel sink, timeout
  // ----------------------------------------
  always #25 ref_clk = ~ref_clk;
  // Sink stalls every other cycle to exercise the hold
  always @(posedge ref_clk) begin
    pix_ready <= ~pix_ready;
    if (pix_valid === 1'b1 && pix_ready === 1'b1) q.push_back(pix);
    cyc++;
    if (cyc > 30000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single word transfer; holds each phase until hready is seen
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge ref_clk);
  endtask

  // Fragment held until taken; caller lowers valid after the list
  task automatic send(input logic l, input logic [4:0] p, input logic [7:0] z,
                      input logic [7:0] a);
    frag_valid <= 1'b1;
    frag <= '{empty: 1'b0, last: l, pix: p, z: {24'h0, z}, alpha: a, mode: fmode};
    do @(posedge ref_clk); while (frag_ready !== 1'b1);
  endtask

  // n-th taken beat of a kind at a pixel as {tag, z}; all ones if absent
  function automatic logic [31:0] nth(input pix_kind_t k, input logic [4:0] p, input int n);
    foreach (q[i]) begin
      if (q[i].kind == k && q[i].pix == p) begin
        if (n == 0) return {q[i].tag, q[i].z[23:0]};
        n--;
      end
    end
    return 32'hffff_ffff;
  endfunction

  // Record at pointer 0x40: word i holds 0x1000+i, optional texture and offset
  task automatic tile(input logic tp, input logic ps, input logic t);
    for (int i = 0; i < 24; i++) u_mem.mem[16 + i] = 32'h1000 + i;
    if (t) u_mem.mem[16] = 32'h0300_0000;
    q.delete();
    fmode = DC_LESS;
    tile_presort <= tp;
    tile_start <= 1'b1;
    @(posedge ref_clk);
    tile_start <= 1'b0;
    send(1'b0, 5'h4, 8'h05, 8'hff);
    send(1'b0, 5'h4, 8'h05, 8'hff);
    send(1'b0, 5'h0, 8'h09, 8'hff);
    send(1'b0, 5'h3, 8'h05, 8'h80);
    send(1'b1, 5'h1, 8'h09, 8'h7f);
    // Pre-sort honours the mode, so translucent entries get a nearer-wins one
    fmode = ps ? DC_GREATER : DC_LESS;
    send(1'b0, 5'h2, 8'h07, 8'h40);
    send(1'b0, 5'h2, 8'h04, 8'h40);
    send(1'b0, 5'h5, 8'h03, 8'h40);
    send(1'b0, 5'h5, 8'h03, 8'h40);
    send(1'b0, 5'h1, 8'h06, 8'h40);
    send(1'b1, 5'h0, 8'h0a, 8'h40);
    frag_valid <= 1'b0;
    chk(trans_modvol_enable, !ps);
    do @(posedge ref_clk); while (tile_done !== 1'b1);
    chk(nth(PK_CUTOUT, 5'h4, 0), 32'h0100_0005);
    chk(nth(PK_CUTOUT, 5'h3, 0), 32'h0100_0005);
    chk(nth(PK_CUTOUT, 5'h0, 0), 32'h0000_0009);
    chk(nth(PK_CUTOUT, 5'h1, 0), 32'hffff_ffff);
    chk(nth(PK_TRANS, 5'h0, 0), 32'hffff_ffff);
    chk(nth(PK_TRANS, 5'h5, 0), 32'h0200_0003);
    chk(nth(PK_TRANS, 5'h2, 0), ps ? 32'h0000_0007 : 32'h0100_0004);
    chk(nth(PK_TRANS, 5'h2, 1), ps ? 32'hffff_ffff : 32'h0000_0007);
    chk(nth(PK_BG, 5'h6, 0) & 32'h00ff_ffff, 32'h2);
    chk(nth(PK_BG, 5'h1, 0), 32'hffff_ffff);
    chk(bg_params.vx[2], t ? 32'h1011 : 32'h100b);
    chk(bg_params.base[2], t ? 32'h1016 : 32'h100e);
    chk(bg_params.vx[3], t ? 32'h1018 : 32'h100f);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    ahb(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'h0010_0800);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0000_00ff);
    ahb(1'b1, 8'h18, 32'h5a, rd);
    ahb(1'b0, 8'h18, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, 8'h00, 32'h40, rd);
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h40);
    ahb(1'b1, 8'h04, 32'h2, rd);
    ahb(1'b1, 8'h10, 32'h80, rd);
    ahb(1'b1, 8'h08, 32'h8800, rd);
    tile(1'b0, 1'b0, 1'b0);
    ahb(1'b1, 8'h0c, 32'h0020_0000, rd);
    tile(1'b1, 1'b1, 1'b1);
    tile(1'b0, 1'b0, 1'b0);
    ahb(1'b1, 8'h0c, 32'h0, rd);
    ahb(1'b1, 8'h08, 32'h8801, rd);
    tile(1'b0, 1'b1, 1'b1);
    ahb(1'b0, 8'h14, 32'h0, rd);
    chk(rd, 32'h0020_0301);
    print_verdict();
  end
endmodule

// file: tex_mem_model.sv
// Texture memory model holding the background record.
// Assumes the bench fills mem; word index is address bits 7:2.
`timescale 1ns/1ps
module tex_mem_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_valid,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:63];
  logic [1:0] wait_q;
  // Latency alternates 1 and 3; data toggles off-beat so stale words never match
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 2'h0;
      mem_valid <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_valid && wait_q == 2'h0) begin
      mem_valid <= 1'b1;
      mem_rdata <= mem[mem_addr[7:2]];
      wait_q <= {mem_addr[2], 1'b1};
    end else begin
      mem_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q <= (wait_q == 2'h0) ? 2'h0 : wait_q - 2'h1;
    end
  end
endmodule
